/* verilog/psc_pkg.sv */
// Constants for the peripheral select control register pair.
// Assumes one 50 MHz clock, synchronous active-high reset, host I/O and RTC index access.
package psc_pkg;

  localparam logic [7:0]  PSC_IDX_CTRL0        = 8'h69;
  localparam logic [7:0]  PSC_IDX_CTRL1        = 8'h6A;
  localparam logic [15:0] PSC_PORT_CTRL0       = 16'h0102;

  localparam int          PSC_C0_BOARD_EN      = 0;
  localparam int          PSC_C0_SERIAL_A_EN   = 2;
  localparam int          PSC_C0_SERIAL_A_DEF  = 3;
  localparam int          PSC_C0_PRINTER_EN    = 4;
  localparam int          PSC_C0_PRINTER_LO    = 5;
  localparam int          PSC_C0_PRINTER_HI    = 6;
  localparam int          PSC_C0_COMPAT_N      = 7;

  localparam int          PSC_C1_SERIAL_B_EN   = 0;
  localparam int          PSC_C1_KBD_TYPE      = 1;
  localparam int          PSC_C1_PRIVATE_CONTROLS_ENABLE       = 2;
  localparam int          PSC_C1_CS_MODE       = 3;

  localparam logic [7:0]  PSC_CTRL0_RESET      = 8'h9D;
  localparam logic [7:0]  PSC_CTRL1_RESET      = 8'h07;
  localparam logic [7:0]  PSC_CTRL0_MASK       = 8'hFD;
  localparam logic [7:0]  PSC_CTRL1_MASK       = 8'h0F;

  localparam logic [15:0] PSC_SERIAL_HI_BASE   = 16'h03F8;
  localparam logic [15:0] PSC_SERIAL_LO_BASE   = 16'h02F8;
  localparam int          PSC_SERIAL_SPAN_LOG2 = 3;
  localparam logic [15:0] PSC_PRINTER_BASE_00  = 16'h03BC;
  localparam logic [15:0] PSC_PRINTER_BASE_01  = 16'h0378;
  localparam logic [15:0] PSC_PRINTER_BASE_10  = 16'h0278;
  localparam int          PSC_PRINTER_SPAN_LOG2 = 2;

  localparam logic [2:0]  PSC_HW_WAIT_COUNT    = 3'h0;
  localparam int          PSC_SIDEBAND_WIDTH   = 3;

  // Printer default field, value given as {bit 6, bit 5}
  typedef enum logic [1:0]
  {
    PSC_PRN_00 = 2'h0,
    PSC_PRN_01 = 2'h2,
    PSC_PRN_10 = 2'h1,
    PSC_PRN_RSV = 2'h3
  } psc_printer_range_e;

endpackage

/* verilog/psc_hw_decode.sv */
// Hardwired address decoder for serial A, serial B and printer ranges.
// Assumes a 16-bit I/O address stable while the access strobe is high.
module psc_hw_decode
  import psc_pkg::*;
(
  input  wire logic [15:0] io_addr,
  input  wire logic        serial_a_default_select,
  input  wire logic        printer_default_bit_lo,
  input  wire logic        printer_default_bit_hi,
  output logic             hit_serial_a,
  output logic             hit_serial_b,
  output logic             hit_printer
);

  logic [15:0] serial_a_base;
  logic [15:0] serial_b_base;
  logic [15:0] printer_base;
  logic        printer_valid;

  always_comb
  begin
    serial_a_base = serial_a_default_select ? PSC_SERIAL_HI_BASE : PSC_SERIAL_LO_BASE;
    serial_b_base = serial_a_default_select ? PSC_SERIAL_LO_BASE : PSC_SERIAL_HI_BASE;
    printer_valid = 1'b1;
    case (psc_printer_range_e'({printer_default_bit_hi, printer_default_bit_lo}))
      PSC_PRN_00: printer_base = PSC_PRINTER_BASE_00;
      PSC_PRN_01: printer_base = PSC_PRINTER_BASE_01;
      PSC_PRN_10: printer_base = PSC_PRINTER_BASE_10;
      default:
      begin
        printer_base  = PSC_PRINTER_BASE_00;
        printer_valid = 1'b0;
      end
    endcase
  end

  assign hit_serial_a = io_addr[15:PSC_SERIAL_SPAN_LOG2] == serial_a_base[15:PSC_SERIAL_SPAN_LOG2];
  assign hit_serial_b = io_addr[15:PSC_SERIAL_SPAN_LOG2] == serial_b_base[15:PSC_SERIAL_SPAN_LOG2];
  assign hit_printer  = printer_valid &&
                        (io_addr[15:PSC_PRINTER_SPAN_LOG2] == printer_base[15:PSC_PRINTER_SPAN_LOG2]);

endmodule

/* verilog/psc_sideband.sv */
// Keyboard sideband pass-through with optional hold.
// Assumes controller outputs are synchronous to clk_sys.
module psc_sideband
  import psc_pkg::*;
#(
  parameter int WIDTH = PSC_SIDEBAND_WIDTH
)
(
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] kbc_out,
  input  wire logic             keyboard_type_select,
  input  wire logic             private_controls_enable,
  output logic      [WIDTH-1:0] sideband_out
);

  logic follow;

  assign follow = !keyboard_type_select || private_controls_enable;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic out_reg;
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
          out_reg <= 1'b0;
        else if (follow)
          out_reg <= kbc_out[gi];
      end
      assign sideband_out[gi] = out_reg;
    end
  endgenerate

endmodule

/* verilog/psc_ctrl_regs.sv */
// Top of the peripheral select control block: two control registers,
// chip select generation and keyboard sideband handling.
// Assumes host I/O strobes and RTC index strobes are one-cycle pulses synchronous to clk_sys.
module psc_ctrl_regs
  import psc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        rtc_wr,
  input  wire logic        rtc_rd,
  input  wire logic [7:0]  rtc_index,
  input  wire logic [7:0]  rtc_wdata,
  output logic      [7:0]  rtc_rdata,
  output logic             rtc_hit,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_reg_hit,
  input  wire logic [2:0]  prog_select_hit,
  input  wire logic [2:0]  prog_wait_count,
  input  wire logic        prog_wide_access,
  output logic             serial_a_select,
  output logic             serial_b_select,
  output logic             printer_select,
  output logic [2:0]       wait_count,
  output logic             wide_io_access_n,
  output logic             printer_compat_mode_n,
  output logic             printer_dir_ctrl_en,
  input  wire logic [2:0]  kbc_out,
  output logic             kbd_sideband_out_a,
  output logic             kbd_sideband_out_b,
  output logic             kbd_sideband_out_c
);

  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] rtc_rdata_reg;
  logic [7:0] io_rdata_reg;
  logic       serial_a_sel_reg;
  logic       serial_b_sel_reg;
  logic       printer_sel_reg;
  logic [2:0] wait_count_reg;
  logic       wide_n_reg;

  logic       rtc_ctrl0;
  logic       rtc_ctrl1;
  logic       io_ctrl0;
  logic       io_cycle;
  logic       hw_hit_a;
  logic       hw_hit_b;
  logic       hw_hit_p;
  logic       hit_a;
  logic       hit_b;
  logic       hit_p;
  logic       serial_a_next;
  logic       serial_b_next;
  logic       printer_next;
  logic       any_sel_next;
  logic       programmed_mode;
  logic [2:0] sideband;

  // Address decode of the two registers
  assign rtc_ctrl0 = rtc_index == PSC_IDX_CTRL0;
  assign rtc_ctrl1 = rtc_index == PSC_IDX_CTRL1;
  assign io_ctrl0  = io_addr == PSC_PORT_CTRL0;
  assign io_cycle  = io_wr || io_rd;
  assign rtc_hit    = (rtc_wr || rtc_rd) && (rtc_ctrl0 || rtc_ctrl1);
  assign io_reg_hit = io_cycle && io_ctrl0;

  // Control register 0, shared by both access paths; the I/O port wins a same-cycle clash
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ctrl0_reg <= PSC_CTRL0_RESET;
    else if (io_wr && io_ctrl0)
      ctrl0_reg <= io_wdata & PSC_CTRL0_MASK;
    else if (rtc_wr && rtc_ctrl0)
      ctrl0_reg <= rtc_wdata & PSC_CTRL0_MASK;
  end

  // Control register 1; unimplemented upper bits never store
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ctrl1_reg <= PSC_CTRL1_RESET;
    else if (rtc_wr && rtc_ctrl1)
      ctrl1_reg <= rtc_wdata & PSC_CTRL1_MASK;
  end

  // RTC index read data; other indices read zero here
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rtc_rdata_reg <= 8'h00;
    else if (rtc_rd)
    begin
      if (rtc_ctrl0)
        rtc_rdata_reg <= ctrl0_reg;
      else if (rtc_ctrl1)
        rtc_rdata_reg <= ctrl1_reg;
      else
        rtc_rdata_reg <= 8'h00;
    end
  end

  // I/O port read data
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      io_rdata_reg <= 8'h00;
    else if (io_rd)
      io_rdata_reg <= io_ctrl0 ? ctrl0_reg : 8'h00;
  end

  assign rtc_rdata = rtc_rdata_reg;
  assign io_rdata  = io_rdata_reg;

  psc_hw_decode u_hw_decode
  (
    .io_addr                 (io_addr),
    .serial_a_default_select (ctrl0_reg[PSC_C0_SERIAL_A_DEF]),
    .printer_default_bit_lo  (ctrl0_reg[PSC_C0_PRINTER_LO]),
    .printer_default_bit_hi  (ctrl0_reg[PSC_C0_PRINTER_HI]),
    .hit_serial_a            (hw_hit_a),
    .hit_serial_b            (hw_hit_b),
    .hit_printer             (hw_hit_p)
  );

  // Decode source chosen by the mode bit
  assign programmed_mode = ctrl1_reg[PSC_C1_CS_MODE];
  assign hit_a = programmed_mode ? prog_select_hit[0] : hw_hit_a;
  assign hit_b = programmed_mode ? prog_select_hit[1] : hw_hit_b;
  assign hit_p = programmed_mode ? prog_select_hit[2] : hw_hit_p;

  // Enables gate each select
  assign serial_a_next = io_cycle && hit_a && ctrl0_reg[PSC_C0_BOARD_EN]
                         && ctrl0_reg[PSC_C0_SERIAL_A_EN];
  assign printer_next  = io_cycle && hit_p && ctrl0_reg[PSC_C0_BOARD_EN]
                         && ctrl0_reg[PSC_C0_PRINTER_EN];
  assign serial_b_next = io_cycle && hit_b && ctrl1_reg[PSC_C1_SERIAL_B_EN];
  assign any_sel_next  = serial_a_next || serial_b_next || printer_next;

  // Registered chip selects
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      serial_a_sel_reg <= 1'b0;
      serial_b_sel_reg <= 1'b0;
      printer_sel_reg  <= 1'b0;
    end
    else
    begin
      serial_a_sel_reg <= serial_a_next;
      serial_b_sel_reg <= serial_b_next;
      printer_sel_reg  <= printer_next;
    end
  end

  // Wait count and 16-bit signalling only in programmed mode
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wait_count_reg <= PSC_HW_WAIT_COUNT;
      wide_n_reg     <= 1'b1;
    end
    else if (any_sel_next && programmed_mode)
    begin
      wait_count_reg <= prog_wait_count;
      wide_n_reg     <= !prog_wide_access;
    end
    else
    begin
      wait_count_reg <= PSC_HW_WAIT_COUNT;
      wide_n_reg     <= 1'b1;
    end
  end

  assign serial_a_select  = serial_a_sel_reg;
  assign serial_b_select  = serial_b_sel_reg;
  assign printer_select   = printer_sel_reg;
  assign wait_count       = wait_count_reg;
  assign wide_io_access_n = wide_n_reg;

  // Printer mode straight from the register
  assign printer_compat_mode_n = ctrl0_reg[PSC_C0_COMPAT_N];
  assign printer_dir_ctrl_en   = !ctrl0_reg[PSC_C0_COMPAT_N];

  psc_sideband #(
    .WIDTH (PSC_SIDEBAND_WIDTH)
  ) u_sideband
  (
    .clk_sys                 (clk_sys),
    .sys_rst                 (sys_rst),
    .kbc_out                 (kbc_out),
    .keyboard_type_select    (ctrl1_reg[PSC_C1_KBD_TYPE]),
    .private_controls_enable (ctrl1_reg[PSC_C1_PRIVATE_CONTROLS_ENABLE]),
    .sideband_out            (sideband)
  );

  assign kbd_sideband_out_a = sideband[0];
  assign kbd_sideband_out_b = sideband[1];
  assign kbd_sideband_out_c = sideband[2];

endmodule

/* testbench/psc_chk.sv */
// Port-level assertions for the control register pair.
// Assumes one clock and a synchronous active-high reset.
module psc_chk
  import psc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        rtc_wr,
  input wire logic        rtc_rd,
  input wire logic [7:0]  rtc_index,
  input wire logic [7:0]  rtc_wdata,
  input wire logic        rtc_hit,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_reg_hit,
  input wire logic [2:0]  prog_select_hit,
  input wire logic [2:0]  prog_wait_count,
  input wire logic        prog_wide_access,
  input wire logic        serial_a_select,
  input wire logic        serial_b_select,
  input wire logic        printer_select,
  input wire logic [2:0]  wait_count,
  input wire logic        wide_io_access_n,
  input wire logic        printer_compat_mode_n,
  input wire logic        printer_dir_ctrl_en,
  input wire logic [2:0]  kbc_out,
  input wire logic        kbd_sideband_out_a,
  input wire logic        kbd_sideband_out_b,
  input wire logic        kbd_sideband_out_c
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c0_reg;
  logic [7:0] c1_reg;
  logic [2:0] sb;
  assign sb = {kbd_sideband_out_c, kbd_sideband_out_b, kbd_sideband_out_a};
  // Shadow of the first register; the I/O port wins a clash
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      c0_reg <= 8'h9D;
    else if (io_wr && io_addr == 16'h0102)
      c0_reg <= io_wdata & 8'hFD;
    else if (rtc_wr && rtc_index == 8'h69)
      c0_reg <= rtc_wdata & 8'hFD;
  end
  // Shadow of the second register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      c1_reg <= 8'h07;
    else if (rtc_wr && rtc_index == 8'h6A)
      c1_reg <= rtc_wdata & 8'h0F;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_idle;
    !(io_rd || io_wr);
  endsequence
  sequence s_follow;
    !$past(sys_rst) && (!$past(c1_reg[1]) || $past(c1_reg[2]));
  endsequence
  a_rtc_hit_decode: assert property (rtc_hit == ((rtc_wr || rtc_rd) && (rtc_index == 8'h69 || rtc_index == 8'h6A)))
    else $error("rtc hit decode wrong");
  a_io_hit_decode: assert property (io_reg_hit == ((io_wr || io_rd) && io_addr == 16'h0102))
    else $error("io hit decode wrong");
  a_sel_no_strobe: assert property (s_idle |=> !(serial_a_select || serial_b_select || printer_select))
    else $error("select without io cycle");
  a_sel_one_only: assert property ($onehot0({serial_a_select, serial_b_select, printer_select}))
    else $error("several selects at once");
  a_hw_no_wait: assert property (!$past(c1_reg[3]) |-> wait_count == 3'h0 && wide_io_access_n)
    else $error("programmed timing in hardwired mode");
  a_wide_cause: assert property (!wide_io_access_n |-> $past(c1_reg[3] && prog_wide_access))
    else $error("wide access without cause");
  a_wait_prog: assert property (wait_count != 3'h0 |-> wait_count == $past(prog_wait_count))
    else $error("wait count not programmed value");
  a_dir_inverse: assert property (printer_dir_ctrl_en == !c0_reg[7] && printer_compat_mode_n == c0_reg[7])
    else $error("direction enable not inverse");
  a_sb_follow: assert property (s_follow |-> sb == $past(kbc_out))
    else $error("sideband not following");
  a_sb_hold: assert property (!$past(sys_rst) && $past(c1_reg[1]) && !$past(c1_reg[2]) |-> $stable(sb))
    else $error("sideband not held");
endmodule

bind psc_ctrl_regs psc_chk u_chk (.*);

/* testbench/psc_kbc_model.sv */
// Far side: keyboard controller outputs and programmed range decoder.
// Assumes the bench seeds the random generator.
module psc_kbc_model
  import psc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [15:0] io_addr,
  output logic      [2:0]  kbc_out,
  output logic      [2:0]  prog_select_hit,
  output logic      [2:0]  prog_wait_count,
  output logic             prog_wide_access
);
  timeunit 1ns;
  timeprecision 1ps;
  // Controller outputs change at random, often standing several cycles
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      kbc_out <= 3'h0;
    else if ($urandom_range(0, 3) == 0)
      kbc_out <= 3'($urandom);
  end
  // Programmed ranges, wait counts and width
  assign prog_select_hit[0] = io_addr[15:3] == 13'h007D;
  assign prog_select_hit[1] = io_addr[15:3] == 13'h005D;
  assign prog_select_hit[2] = io_addr[15:2] == 14'h0040;
  assign prog_wait_count = prog_select_hit[0] ? 3'h1 : prog_select_hit[1] ? 3'h3 : 3'h7;
  assign prog_wide_access = prog_select_hit[1];
endmodule

/* testbench/tb_psc_ctrl_regs.sv */
// Self-checking bench for the control register pair.
// Assumes the partner model and the bound checker.
module tb_psc_ctrl_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  logic        clk_sys = 1'b0, sys_rst = 1'b1;
  logic        rtc_wr = 1'b0, rtc_rd = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic [7:0]  rtc_index = 8'h00, rtc_wdata = 8'h00, io_wdata = 8'h00;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0]  rtc_rdata, io_rdata;
  logic [2:0]  kbc_out, prog_select_hit, prog_wait_count, wait_count, sb_exp;
  logic        prog_wide_access, rtc_hit, io_reg_hit, serial_a_select, serial_b_select;
  logic        printer_select, wide_io_access_n, printer_compat_mode_n, printer_dir_ctrl_en;
  logic        kbd_sideband_out_a, kbd_sideband_out_b, kbd_sideband_out_c;
  int          n_mismatch = 0, n_compared = 0, c0 = 'h9D, c1 = 'h07;
  int          addrs[9] = '{'h3F8, 'h2F8, 'h3BC, 'h378, 'h278, 'h3E8, 'h2E8, 'h100, 'h102};
  logic [31:0] r;

  psc_ctrl_regs dut (.*);
  psc_kbc_model u_partner (.*);

  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end

  // Expected sideband, one cycle behind the controller when passing
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      sb_exp <= 3'h0;
    else if (!c1[1] || c1[2])
      sb_exp <= kbc_out;
  end

  function automatic logic [2:0] exp_sel(int a, logic [2:0] ph);
    int pa, pc;
    logic [2:0] h;
    pa = c0[3] ? 'h3F8 : 'h2F8;
    pc = c0[6:5] == 0 ? 'h3BC : c0[6:5] == 2 ? 'h378 : c0[6:5] == 1 ? 'h278 : -1;
    h = {(a >> 2) == (pc >> 2), (a >> 3) == ((pa ^ 'h100) >> 3), (a >> 3) == (pa >> 3)};
    if (c1[3])
      h = ph;
    return h & {c0[0] & c0[4], c1[0], c0[0] & c0[2]};
  endfunction

  task chk(input string n, input int e, input logic [7:0] g);
    n_compared++;
    if (g !== 8'(e))
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, 8'(e), g);
    end
  endtask

  task rtc_cyc(input logic [7:0] idx, input logic rd, input logic [7:0] d);
    @(posedge clk_sys);
    rtc_index <= idx;
    rtc_rd <= rd;
    rtc_wr <= !rd;
    rtc_wdata <= d;
    @(posedge clk_sys);
    rtc_rd <= 1'b0;
    rtc_wr <= 1'b0;
    #1;
    if (rd)
      chk("rtc_rdata", idx == 8'h69 ? c0 : idx == 8'h6A ? c1 : 0, rtc_rdata);
    else if (idx == 8'h69)
      c0 = d & 'hFD;
    else if (idx == 8'h6A)
      c1 = d & 'h0F;
    chk("compat_n", c0[7], {7'h0, printer_compat_mode_n});
  endtask

  task io_cyc(input logic [15:0] a, input logic rd, input logic [7:0] d);
    logic [2:0] ph, pw, es;
    logic pwd;
    @(posedge clk_sys);
    io_addr <= a;
    io_rd <= rd;
    io_wr <= !rd;
    io_wdata <= d;
    @(posedge clk_sys);
    ph = prog_select_hit;
    pw = prog_wait_count;
    pwd = prog_wide_access;
    es = exp_sel(a, ph);
    io_rd <= 1'b0;
    io_wr <= 1'b0;
    #1;
    chk("selects", es, {printer_select, serial_b_select, serial_a_select});
    chk("wait", (c1[3] && es != 0) ? pw : 0, wait_count);
    chk("wide_n", !(c1[3] && es != 0 && pwd), wide_io_access_n);
    chk("sideband", sb_exp, {kbd_sideband_out_c, kbd_sideband_out_b, kbd_sideband_out_a});
    if (rd && a == 16'h0102)
      chk("io_rdata", c0, io_rdata);
    else if (a == 16'h0102)
      c0 = d & 'hFD;
  endtask

  task end_of_test;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    r = $urandom(32'h3143be69);
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rtc_cyc(8'h69, 1'b1, 8'h00);
    rtc_cyc(8'h6A, 1'b1, 8'h00);
    io_cyc(16'h0102, 1'b1, 8'h00);
    io_cyc(16'h03F8, 1'b1, 8'h00);
    rtc_cyc(8'h6B, 1'b1, 8'h00);
    rtc_cyc(8'h6A, 1'b0, 8'h05);
    for (int i = 0; i < 80; i++)
    begin
      r = $urandom;
      if (r[0])
        rtc_cyc(8'h69, 1'b0, r[15:8]);
      else
        io_cyc(16'h0102, 1'b0, r[15:8]);
      if (r[3:1] == 3'h0)
        rtc_cyc(8'h6A, 1'b0, {4'h0, r[19:16]});
      rtc_cyc(r[4] ? 8'h6A : 8'h69, 1'b1, 8'h00);
      for (int k = 0; k < 9; k++)
      begin
        r = $urandom;
        io_cyc(16'(addrs[k] + int'(r[2:0])), r[3], r[15:8]);
      end
    end
    end_of_test();
  end
endmodule
